// ### hdl/cdc_ctrl_port.sv
// Two-wire control port, register file and reset sequencing
`timescale 1ns/10ps
`default_nettype none

// Notes on behaviour
// - Answer only target address 0011000; other addresses are not acknowledged.
// - Target only: never starts transfers, never drives the clock line.
// - Registers are 8 bits; each data byte maps to one register.
// - Every writable register except the page 0 reset trigger (register 1, which reads zero) reads back its stored value.
// - Pointer advances by one after each data byte, read or write.
// - Works with clock line up to 400 kHz (fast) or 100 kHz.
// - Pin reset or software reset returns everything to defaults.
// - Writing one to bit 0 of page 0 register 1 resets all.
// - Memory init ends 1 ms after reset; no coefficient writes meanwhile.
// - All blocks start powered down; power-down keeps register settings.
module cdc_ctrl_port
  import cdc_pkg::*;
#(
  parameter int PAGES = 2, // Register pages held
  parameter int INIT_CYCLES = INIT_CYCLES_DEF // Init window in cycles
) (
  input wire logic clk_sys, // 100 MHz system clock
  input wire logic sys_rst, // Synchronous reset, high
  input wire logic rst_pin_n, // Reset pin, active low
  input wire logic scl_i, // Bus clock input
  input wire logic sda_i, // Bus data input
  output logic sda_o, // Bus data out, always low
  output logic sda_oe_n, // Low while pulling data low
  output logic init_busy, // Memory initialisation running
  output logic [7:0] blk_pwr, // Block power enables
  output logic [7:0] page_sel // Current register page
);
  localparam int PW = $clog2(PAGES);

  typedef enum logic [6:0] {
    ST_IDLE = 7'b0000001,
    ST_ADDR = 7'b0000010,
    ST_ACKA = 7'b0000100,
    ST_WDAT = 7'b0001000,
    ST_ACKW = 7'b0010000,
    ST_RDAT = 7'b0100000,
    ST_ACKR = 7'b1000000
  } cdc_state_t;

  ////////////////////////////////////////////////////////////////////////
  // Pin synchronisers: three stages, change taken when stages 2 and 3 agree
  logic [2:0] scl_s_q, sda_s_q, rpin_s_q;
  logic scl_f_q, sda_f_q, rpin_f_q;

  always_ff @(posedge clk_sys) begin
    if (sys_rst) begin
      scl_s_q <= SYNC_RST_VAL;
      sda_s_q <= SYNC_RST_VAL;
      rpin_s_q <= SYNC_RST_VAL;
      scl_f_q <= 1'b1;
      sda_f_q <= 1'b1;
      rpin_f_q <= 1'b1;
    end else begin
      scl_s_q <= {scl_s_q[1:0], scl_i};
      sda_s_q <= {sda_s_q[1:0], sda_i};
      rpin_s_q <= {rpin_s_q[1:0], rst_pin_n};
      if (scl_s_q[1] == scl_s_q[2]) scl_f_q <= scl_s_q[2];
      if (sda_s_q[1] == sda_s_q[2]) sda_f_q <= sda_s_q[2];
      if (rpin_s_q[1] == rpin_s_q[2]) rpin_f_q <= rpin_s_q[2];
    end
  end

  // Bus events; sampling at 100 MHz leaves wide margin at 400 kHz
  wire scl_new = (scl_s_q[1] == scl_s_q[2]) ? scl_s_q[2] : scl_f_q;
  wire sda_new = (sda_s_q[1] == sda_s_q[2]) ? sda_s_q[2] : sda_f_q;
  wire scl_rise = scl_new & ~scl_f_q;
  wire scl_fall = ~scl_new & scl_f_q;
  wire bus_start = scl_f_q & scl_new & sda_f_q & ~sda_new;
  wire bus_stop = scl_f_q & scl_new & ~sda_f_q & sda_new;

  ////////////////////////////////////////////////////////////////////////
  // Reset combination; a pin pulse of 10 ns is filtered out, as stages 2 and 3
  // must both sample it low, so the pin is expected held for a few clocks
  logic soft_q;
  wire core_rst = sys_rst | ~rpin_f_q | soft_q;

  // Init window counter restarts on every reset
  logic [$clog2(INIT_CYCLES+1)-1:0] init_cnt_q;
  always_ff @(posedge clk_sys) begin
    if (core_rst) init_cnt_q <= '0;
    else if (init_busy) init_cnt_q <= init_cnt_q + 1'b1;
  end
  assign init_busy = (init_cnt_q != INIT_CYCLES[$bits(init_cnt_q)-1:0]);

  ////////////////////////////////////////////////////////////////////////
  // Protocol state
  cdc_state_t st_q, st_d;
  logic [3:0] bit_q;
  logic [7:0] sh_q;
  logic [7:0] tx_q;
  logic [7:0] ptr_q;
  logic first_q, rd_q, mack_q;
  logic [7:0] page_q;
  logic [7:0] regs_q [PAGES*256];

  wire [PW-1:0] pg = page_q[PW-1:0];
  wire addr_hit = (sh_q[7:1] == TGT_ADDR);
  wire byte_done = (bit_q == BITS_PER_BYTE);
  wire [7:0] ptr_nx = ptr_q + 8'h01;

  // Read data mux; reset trigger reads back zero as it self-clears
  function automatic logic [7:0] rd_val(input logic [7:0] a);
    logic [7:0] v;
    v = regs_q[{pg, a}];
    if (a == OFS_PAGE) v = page_q;
    else if (a == OFS_SWRST && pg == '0) v = 8'h00;
    return v;
  endfunction

  // Write commit at end of the acknowledge slot of a data byte
  wire wr_ev = (st_q == ST_ACKW) & scl_fall & ~first_q;
  wire wr_blk = init_busy & ((pg != '0) | (ptr_q == OFS_PWR));
  wire wr_page = wr_ev & (ptr_q == OFS_PAGE);
  wire wr_soft = wr_ev & (pg == '0) & (ptr_q == OFS_SWRST) &
                 sh_q[SWRST_BIT];
  wire wr_arr = wr_ev & ~wr_blk & (ptr_q != OFS_PAGE) &
                ~((pg == '0) & (ptr_q == OFS_SWRST));

  // Next state
  always_comb begin
    st_d = st_q;
    case (st_q)
      ST_IDLE: st_d = ST_IDLE;
      ST_ADDR: begin
        if (scl_fall && byte_done) st_d = addr_hit ? ST_ACKA : ST_IDLE;
      end
      ST_ACKA: begin
        if (scl_fall) st_d = rd_q ? ST_RDAT : ST_WDAT;
      end
      ST_WDAT: begin
        if (scl_fall && byte_done) st_d = ST_ACKW;
      end
      ST_ACKW: begin
        if (scl_fall) st_d = ST_WDAT;
      end
      ST_RDAT: begin
        if (scl_fall && bit_q == 4'h7) st_d = ST_ACKR;
      end
      ST_ACKR: begin
        if (scl_fall) st_d = mack_q ? ST_RDAT : ST_IDLE;
      end
      default: st_d = ST_IDLE;
    endcase
    if (bus_stop) st_d = ST_IDLE;
    if (bus_start) st_d = ST_ADDR;
  end

  // State, bit counter and shift registers
  always_ff @(posedge clk_sys) begin
    if (core_rst) begin
      st_q <= ST_IDLE;
      bit_q <= '0;
      sh_q <= '0;
      tx_q <= '0;
      rd_q <= 1'b0;
      mack_q <= 1'b0;
      first_q <= 1'b1;
    end else begin
      st_q <= st_d;
      if (bus_start) begin
        bit_q <= '0;
        first_q <= 1'b1;
      end else if (scl_rise && (st_q == ST_ADDR || st_q == ST_WDAT)) begin
        sh_q <= {sh_q[6:0], sda_new};
        bit_q <= bit_q + 4'h1;
      end else if (scl_rise && st_q == ST_ACKR) begin
        mack_q <= ~sda_new;
      end else if (scl_fall) begin
        case (st_q)
          ST_ADDR: if (byte_done) rd_q <= sh_q[0];
          ST_ACKA: begin
            bit_q <= '0;
            tx_q <= rd_val(ptr_q);
          end
          ST_ACKW: begin
            bit_q <= '0;
            first_q <= 1'b0;
          end
          ST_RDAT: begin
            tx_q <= {tx_q[6:0], 1'b0};
            bit_q <= bit_q + 4'h1;
          end
          ST_ACKR: begin
            bit_q <= '0;
            tx_q <= rd_val(ptr_nx);
          end
          default: bit_q <= bit_q;
        endcase
      end
    end
  end

  // Register pointer: first written byte loads it, each data byte bumps it
  always_ff @(posedge clk_sys) begin
    if (core_rst) ptr_q <= '0;
    else if ((st_q == ST_ACKW) && scl_fall) ptr_q <= first_q ? sh_q : ptr_nx;
    else if ((st_q == ST_ACKR) && scl_fall) ptr_q <= ptr_nx;
  end

  // Page select and register array, cleared on every reset
  always_ff @(posedge clk_sys) begin
    if (core_rst) begin
      page_q <= PAGE_RST_VAL;
      for (int i = 0; i < PAGES*256; i++) regs_q[i] <= REG_RST_VAL;
    end else begin
      if (wr_page) page_q <= sh_q;
      if (wr_arr) regs_q[{pg, ptr_q}] <= sh_q;
    end
  end

  // Software reset pulse: one cycle; its reset branch takes outside resets only
  always_ff @(posedge clk_sys) begin
    if (sys_rst || !rpin_f_q) soft_q <= 1'b0;
    else soft_q <= wr_soft;
  end

  ////////////////////////////////////////////////////////////////////////
  // Data line drive: only ever pulls low, clock line is never driven
  wire drv_low = (st_q == ST_ACKA) | (st_q == ST_ACKW) |
                 ((st_q == ST_RDAT) & ~tx_q[7]);
  assign sda_o = 1'b0;
  assign sda_oe_n = ~drv_low;
  assign blk_pwr = regs_q[{{PW{1'b0}}, OFS_PWR}];
  assign page_sel = page_q;
endmodule

`default_nettype wire

// ### hdl/cdc_pkg.sv
// Constants shared by the codec control port
package cdc_pkg;
  localparam logic [6:0] TGT_ADDR = 7'h18; // Fixed target address 001 1000
  localparam logic [7:0] OFS_PAGE = 8'h00; // Page select, every page
  localparam logic [7:0] OFS_SWRST = 8'h01; // Software reset, page 0
  localparam int SWRST_BIT = 0; // Reset trigger bit
  localparam logic [7:0] OFS_PWR = 8'h02; // Block power enables, page 0
  localparam logic [7:0] REG_RST_VAL = 8'h00; // All registers power up zero
  localparam logic [7:0] PAGE_RST_VAL = 8'h00;
  localparam int CLK_MHZ = 100; // System clock rate
  localparam int INIT_TIME_US = 1000; // Memory init window, 1 ms
  localparam int INIT_CYCLES_DEF = INIT_TIME_US * CLK_MHZ;
  localparam logic [2:0] SYNC_RST_VAL = 3'h7; // Idle bus / released pin
  localparam logic [3:0] BITS_PER_BYTE = 4'h8;
endpackage

// ### test/cdc_ctrl_checker.sv
// Assertions on the control port pins
`timescale 1ns/10ps
`default_nettype none
module cdc_ctrl_checker #(
  parameter int INIT_CYCLES = 900 // Init window
) (
  input wire logic clk_sys, // Clock
  input wire logic sys_rst, // Reset
  input wire logic rst_pin_n, // Reset pin
  input wire logic scl_i, // Bus clock
  input wire logic sda_i, // Bus data
  input wire logic sda_o, // Data out
  input wire logic sda_oe_n, // Pull enable
  input wire logic init_busy, // Init window
  input wire logic [7:0] blk_pwr, // Power enables
  input wire logic [7:0] page_sel // Page
);
  localparam int BMAX = INIT_CYCLES + 8;
  default clocking @(posedge clk_sys); endclocking
  // Resets release the bus and clear state
  rst_out_a: assert property (sys_rst |=> sda_oe_n && init_busy)
    else $error("reset left outputs live");
  rst_reg_a: assert property (sys_rst |=> blk_pwr == 8'h00)
    else $error("reset left power on");
  pin_rst_a: assert property ((!rst_pin_n) [*6] |=> init_busy)
    else $error("pin reset ignored");
  // Init window length; writes to power held off inside it
  busy_on_a: assert property ($fell(sys_rst) |-> init_busy [*8])
    else $error("init window too short");
  busy_end_a: assert property (
    $fell(sys_rst) |-> ##[1:BMAX] !init_busy) else $error("init stuck");
  pwr_lock_a: assert property (disable iff (sys_rst)
    init_busy [*2] |=> $stable(blk_pwr)) else $error("power set in init");
  // Open drain only, and data moves only while the clock is low
  od_low_a: assert property (disable iff (sys_rst) sda_o == 1'b0)
    else $error("data driven high");
  sda_move_a: assert property (disable iff (sys_rst)
    !$stable(sda_oe_n) |-> !scl_i) else $error("data moved, clock high");
endmodule
bind cdc_ctrl_port cdc_ctrl_checker #(.INIT_CYCLES(INIT_CYCLES)) u_chk (
  .clk_sys(clk_sys), .sys_rst(sys_rst), .rst_pin_n(rst_pin_n),
  .scl_i(scl_i), .sda_i(sda_i), .sda_o(sda_o), .sda_oe_n(sda_oe_n),
  .init_busy(init_busy), .blk_pwr(blk_pwr), .page_sel(page_sel));
`default_nettype wire

// ### test/cdc_host.sv
// Host bus master model with pull-up on data
`timescale 1ns/10ps
`default_nettype none
module cdc_host (
  input wire logic clk_sys, // Pacing clock
  input wire logic sda_oe_n, // Device pulls low
  output logic scl = 1'b1, // Bus clock, host only
  output logic sda, // Resolved data wire
  output logic [8:0] res = 9'h000, // Byte and ack seen
  output int res_n = 0 // Result count
);
  logic drv = 1'b1;
  int hp = 10; // Half period in clocks; raise for slow bus
  // Pull-up: released wire reads high
  assign sda = drv & sda_oe_n;
  // Start when a is high, stop when low
  task automatic cnd(input logic a);
    drv = a;
    repeat (5) @(negedge clk_sys);
    scl = 1'b1;
    repeat (hp) @(negedge clk_sys);
    drv = !a;
    repeat (hp) @(negedge clk_sys);
    scl = !a;
  endtask
  // Nine bit slots; m drives the ack slot
  task automatic xb(input logic [7:0] d, input logic m);
    logic [8:0] t;
    logic [8:0] v;
    t = {d, m};
    for (int i = 8; i >= 0; i--) begin
      drv = t[i];
      repeat (hp) @(negedge clk_sys);
      scl = 1'b1;
      repeat (hp) @(negedge clk_sys);
      v[i] = sda;
      scl = 1'b0;
    end
    res = v;
    res_n++;
  endtask
endmodule
`default_nettype wire

// ### test/tb_cdc_ctrl_port.sv
// Self-checking bench for the control port
`timescale 1ns/10ps
`default_nettype none
module tb_cdc_ctrl_port;
  import cdc_pkg::*;
  logic clk_sys = 1'b0;
  logic sys_rst = 1'b1;
  logic rst_pin_n = 1'b0; // Held low while supplies come up
  logic scl, sda, sda_o, sda_oe_n, init_busy;
  logic [7:0] blk_pwr, page_sel, p;
  logic [7:0] d [3];
  logic [8:0] res;
  logic [8:0] q [$];
  int res_n;
  int fails = 0;
  int n_checks = 0;
  localparam logic [7:0] AW = {TGT_ADDR, 1'b0};
  always #5 clk_sys = ~clk_sys;
  cdc_host u_cdc_host (.clk_sys(clk_sys), .sda_oe_n(sda_oe_n), .scl(scl),
    .sda(sda), .res(res), .res_n(res_n));
  cdc_ctrl_port #(.INIT_CYCLES(900)) u_cdc_ctrl_port (.clk_sys(clk_sys),
    .sys_rst(sys_rst), .rst_pin_n(rst_pin_n), .scl_i(scl), .sda_i(sda),
    .sda_o(sda_o), .sda_oe_n(sda_oe_n), .init_busy(init_busy),
    .blk_pwr(blk_pwr), .page_sel(page_sel));
  task automatic chk(input logic [8:0] g, input logic [8:0] e);
    n_checks++;
    if (g !== e) begin
      fails++;
      $display("Error %0t: got %h want %h", $time, g, e);
    end
  endtask
  // Note the expectation, then run the byte
  task automatic tx(input logic [7:0] b, input logic m, input logic [8:0] e);
    q.push_back(e);
    u_cdc_host.xb(b, m);
  endtask
  task automatic wr(input logic [7:0] b);
    tx(b, 1'b1, {b, 1'b0});
  endtask
  task automatic wseq(input logic [7:0] r, input logic [7:0] v);
    u_cdc_host.cnd(1'b1);
    wr(AW);
    wr(r);
    wr(v);
    u_cdc_host.cnd(1'b0);
  endtask
  task automatic wb();
    for (int n = 0; n < 1000 && init_busy !== 1'b0; n++) @(negedge clk_sys);
  endtask
  task automatic summarize();
    $display("checks %0d fails %0d", n_checks, fails);
    if (fails == 0 && n_checks > 0) $display("TB: PASS");
    else $display("TB: FAIL");
    $finish;
  endtask
  // Watcher pairs each bus result with the oldest note
  always @(res_n) chk(res, q.pop_front());
  initial begin
    void'($urandom(32'h4ccb48a9));
    repeat (5) @(negedge clk_sys);
    sys_rst = 1'b0;
    rst_pin_n = 1'b1;
    repeat (4) @(negedge clk_sys);
    p = 8'($urandom) | 8'h01;
    wseq(OFS_PWR, p);
    wb();
    chk({blk_pwr, init_busy}, 9'h000);
    $display("lockout done");
    // Burst write from the power register, then slow read back
    foreach (d[i]) d[i] = (i == 0) ? p : 8'($urandom);
    u_cdc_host.cnd(1'b1);
    wr(AW);
    wr(OFS_PWR);
    foreach (d[i]) wr(d[i]);
    u_cdc_host.cnd(1'b0);
    chk({blk_pwr, 1'b0}, {p, 1'b0});
    u_cdc_host.hp = 40;
    u_cdc_host.cnd(1'b1);
    wr(AW);
    wr(OFS_PWR);
    u_cdc_host.cnd(1'b1);
    wr(AW | 8'h01);
    foreach (d[i]) tx(8'hFF, i == 2, {d[i], i == 2});
    u_cdc_host.cnd(1'b0);
    u_cdc_host.hp = 10;
    $display("burst done");
    // Neighbouring addresses stay unanswered
    foreach (d[i]) begin
      u_cdc_host.cnd(1'b1);
      p = {TGT_ADDR ^ (7'h01 << (2 * i)), 1'b0};
      tx(p, 1'b1, {p, 1'b1});
      u_cdc_host.cnd(1'b0);
    end
    $display("address done");
    wseq(OFS_SWRST, 8'h01 << SWRST_BIT);
    chk({blk_pwr, !init_busy}, 9'h000);
    wb();
    wseq(OFS_PWR, d[1] | 8'h01);
    // Page select must show the write and drop back on pin reset
    wseq(OFS_PAGE, 8'h01);
    chk({page_sel, sda_o}, 9'h002);
    rst_pin_n = 1'b0;
    repeat (8) @(negedge clk_sys);
    rst_pin_n = 1'b1;
    chk({blk_pwr, !init_busy}, 9'h000);
    chk({page_sel, sda_o}, 9'h000);
    $display("resets done");
    summarize();
  end
  // Watchdog well beyond the expected run length
  initial begin
    repeat (40000) @(posedge clk_sys);
    fails++;
    summarize();
  end
endmodule
`default_nettype wire
